// >>> design/liu_term_jitter_tx_config.sv
// Termination, jitter attenuator and transmitter configuration bank with transmit path
`timescale 1ns/10ps
// Function
// [R1] Transmit termination code: 75/120/100/110 or external
// [R2] Software picks external transmit resistors only in E1
// [R3] Receive termination field uses the same encoding
// [R4] Jitter limit mode bit, set after reset
// [R5] Placement: off, transmit path or receive path
// [R6] Elastic store depth 128, 64 or 32 bits
// [R7] Bandwidth bit picks corner per line standard
// [R8] Power down silences transmitter, driver high impedance
// [R9] Invert bit flips transmit input polarity
// [R10] Edge select picks falling or rising sample
// [R11] Mode 00: single rail through HDB3/B8ZS encoder
// [R12] Mode 01: single rail, plain AMI encoding
// [R13] Mode 1x: encoder bypassed, dual rail input
// [R14] Global bit picks E1 or T1/J1 settings
// [R15] Substitution is HDB3 in E1, B8ZS in T1
// [R16] Reserved bits read zero, ignore writes
module liu_term_jitter_tx_config (
  // System clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Termination selects
  output logic [6:0] tx_term_ohms_out,
  output logic tx_term_ext_out,
  output logic [6:0] rx_term_ohms_out,
  output logic rx_term_ext_out,
  // Jitter attenuator setup
  output logic jitter_limit_mode_out,
  output logic ja_tx_path_out,
  output logic ja_rx_path_out,
  output logic [7:0] jitter_depth_bits_out,
  output logic [9:0] jitter_corner_chz_out,
  output logic line_t1_out,
  // Transmit system side, on the transmit clock
  input wire logic transmit_clock_in,
  input wire logic tx_single_rail_input_in,
  input wire logic tx_positive_rail_in,
  input wire logic tx_negative_rail_in,
  // Line driver, on the transmit clock
  output logic tx_line_pos_out,
  output logic tx_line_neg_out,
  output logic tx_driver_oe_n_out
);

  // Configuration registers
  logic [7:0] global_reg;
  logic [7:0] term_reg;
  logic [7:0] jitter_reg;
  logic [7:0] txcfg_reg;
  logic [7:0] rd_mux;

  // Transmit clock domain state
  logic link_rst_meta_reg;
  logic link_rst_reg;
  logic [liu_cfg_pkg::SYNC_W-1:0] cfg_sys;
  logic [liu_cfg_pkg::SYNC_W-1:0] cfg_meta_reg;
  logic [liu_cfg_pkg::SYNC_W-1:0] cfg_link_reg;
  logic [liu_cfg_pkg::SYNC_W-1:0] cfg_last_reg;
  logic [liu_cfg_pkg::SYNC_W-1:0] cfg_use_reg;
  logic t1_s;
  logic off_s;
  logic inv_s;
  logic edge_s;
  logic [1:0] mode_s;
  logic [2:0] fall_smp_reg;
  logic [2:0] rise_smp_reg;
  logic [2:0] picked;
  logic [2:0] data_reg;
  logic enc_pos;
  logic enc_neg;

  // Code to impedance; a leading one means external resistors
  function automatic logic [6:0] term_ohms(input logic [2:0] code);
    logic [6:0] ohms;
    if (code[liu_cfg_pkg::TERM_EXT]) ohms = liu_cfg_pkg::OHM_EXT;
    else if (code[1:0] == liu_cfg_pkg::TERM_75) ohms = liu_cfg_pkg::OHM_75;
    else if (code[1:0] == liu_cfg_pkg::TERM_120) ohms = liu_cfg_pkg::OHM_120;
    else if (code[1:0] == liu_cfg_pkg::TERM_100) ohms = liu_cfg_pkg::OHM_100;
    else ohms = liu_cfg_pkg::OHM_110;
    return ohms;
  endfunction : term_ohms

  // Register writes; reserved bits are masked so they stay zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      global_reg <= liu_cfg_pkg::RST_GLOBAL;
      term_reg <= liu_cfg_pkg::RST_TERM;
      jitter_reg <= liu_cfg_pkg::RST_JITTER; // R4
      txcfg_reg <= liu_cfg_pkg::RST_TXCFG;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        liu_cfg_pkg::ADDR_GLOBAL: global_reg <= reg_wdata_in & liu_cfg_pkg::MASK_GLOBAL; // R16
        liu_cfg_pkg::ADDR_TERM: term_reg <= reg_wdata_in & liu_cfg_pkg::MASK_TERM; // R16
        liu_cfg_pkg::ADDR_JITTER: jitter_reg <= reg_wdata_in & liu_cfg_pkg::MASK_JITTER; // R16
        liu_cfg_pkg::ADDR_TXCFG: txcfg_reg <= reg_wdata_in & liu_cfg_pkg::MASK_TXCFG; // R16
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    case (reg_addr_in)
      liu_cfg_pkg::ADDR_GLOBAL: rd_mux = global_reg;
      liu_cfg_pkg::ADDR_TERM: rd_mux = term_reg;
      liu_cfg_pkg::ADDR_JITTER: rd_mux = jitter_reg;
      liu_cfg_pkg::ADDR_TXCFG: rd_mux = txcfg_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stand one cycle only, zero otherwise
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Termination decode for the analog front end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_term_ohms_out <= liu_cfg_pkg::OHM_75;
      tx_term_ext_out <= 1'b0;
      rx_term_ohms_out <= liu_cfg_pkg::OHM_75;
      rx_term_ext_out <= 1'b0;
    end else begin
      // External transmit resistors are only sane in E1; software keeps to that
      tx_term_ohms_out <= term_ohms(term_reg[liu_cfg_pkg::TX_TERM_LSB +: 3]); // R1
      tx_term_ext_out <= term_reg[liu_cfg_pkg::TX_TERM_LSB + liu_cfg_pkg::TERM_EXT]; // R1
      rx_term_ohms_out <= term_ohms(term_reg[liu_cfg_pkg::RX_TERM_LSB +: 3]); // R3
      rx_term_ext_out <= term_reg[liu_cfg_pkg::RX_TERM_LSB + liu_cfg_pkg::TERM_EXT]; // R3
    end
  end

  // Jitter attenuator placement, depth and limit mode
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      jitter_limit_mode_out <= 1'b1;
      ja_tx_path_out <= 1'b0;
      ja_rx_path_out <= 1'b0;
      jitter_depth_bits_out <= liu_cfg_pkg::DEPTH_128;
    end else begin
      jitter_limit_mode_out <= jitter_reg[liu_cfg_pkg::JITTER_LIMIT_MODE]; // R4
      // Codes 00 and 10 both leave the attenuator out
      ja_tx_path_out <= jitter_reg[liu_cfg_pkg::JA_PLACE_LSB +: 2] == liu_cfg_pkg::PLACE_TX; // R5
      ja_rx_path_out <= jitter_reg[liu_cfg_pkg::JA_PLACE_LSB +: 2] == liu_cfg_pkg::PLACE_RX; // R5
      if (jitter_reg[liu_cfg_pkg::JA_DEPTH_LSB +: 2] == liu_cfg_pkg::DEPTH_CODE_128) begin
        jitter_depth_bits_out <= liu_cfg_pkg::DEPTH_128; // R6
      end else if (jitter_reg[liu_cfg_pkg::JA_DEPTH_LSB +: 2] == liu_cfg_pkg::DEPTH_CODE_64) begin
        jitter_depth_bits_out <= liu_cfg_pkg::DEPTH_64; // R6
      end else begin
        jitter_depth_bits_out <= liu_cfg_pkg::DEPTH_32; // R6
      end
    end
  end

  // Corner frequency depends on bandwidth bit and line standard
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      jitter_corner_chz_out <= liu_cfg_pkg::CORNER_E1_WIDE;
      line_t1_out <= 1'b0;
    end else begin
      line_t1_out <= global_reg[liu_cfg_pkg::GLB_T1]; // R14
      unique case ({jitter_reg[liu_cfg_pkg::JA_BW], global_reg[liu_cfg_pkg::GLB_T1]})
        2'b00: jitter_corner_chz_out <= liu_cfg_pkg::CORNER_E1_WIDE; // R7
        2'b01: jitter_corner_chz_out <= liu_cfg_pkg::CORNER_T1_WIDE; // R7
        2'b10: jitter_corner_chz_out <= liu_cfg_pkg::CORNER_E1_NARROW; // R7
        2'b11: jitter_corner_chz_out <= liu_cfg_pkg::CORNER_T1_NARROW; // R7
      endcase
    end
  end

  // Reset into the transmit clock domain; needs running edges to take effect
  always_ff @(posedge transmit_clock_in) begin
    link_rst_meta_reg <= sys_rst_in;
    link_rst_reg <= link_rst_meta_reg;
  end

  // Quasi-static config bits, each through its own two flops
  assign cfg_sys = {global_reg[liu_cfg_pkg::GLB_T1],
                    txcfg_reg[liu_cfg_pkg::TX_OFF],
                    txcfg_reg[liu_cfg_pkg::TX_INV],
                    txcfg_reg[liu_cfg_pkg::TX_EDGE],
                    txcfg_reg[liu_cfg_pkg::TX_MODE_LSB +: 2]};

  genvar gi;
  generate
    for (gi = 0; gi < liu_cfg_pkg::SYNC_W; gi++) begin : g_cfg_sync
      // A change may land on the two halves of the mode field one edge apart
      always_ff @(posedge transmit_clock_in) begin
        cfg_meta_reg[gi] <= cfg_sys[gi];
        cfg_link_reg[gi] <= cfg_meta_reg[gi];
      end
    end
  endgenerate

  // Take the bits only when two samples agree, so a skewed field never
  // shows a mixed mode code to the encoder
  always_ff @(posedge transmit_clock_in) begin
    cfg_last_reg <= cfg_link_reg;
    if (cfg_link_reg == cfg_last_reg) begin
      cfg_use_reg <= cfg_link_reg;
    end
  end

  assign {t1_s, off_s, inv_s, edge_s, mode_s} = cfg_use_reg;

  // Capture inputs on both edges; the select picks one
  always_ff @(negedge transmit_clock_in) begin
    fall_smp_reg <= {tx_single_rail_input_in, tx_positive_rail_in, tx_negative_rail_in};
  end

  always_ff @(posedge transmit_clock_in) begin
    rise_smp_reg <= {tx_single_rail_input_in, tx_positive_rail_in, tx_negative_rail_in};
  end

  assign picked = edge_s ? rise_smp_reg : fall_smp_reg; // R10

  // Polarity fix applies to single and dual rail alike
  always_ff @(posedge transmit_clock_in) begin
    if (link_rst_reg) begin
      data_reg <= 3'h0;
    end else begin
      data_reg <= picked ^ {3{inv_s}}; // R9
    end
  end

  // Line encoder, fed in the mode chosen by software
  tx_line_encoder u_encoder (
    .clk_in(transmit_clock_in),
    .rst_in(link_rst_reg),
    .mode_in(mode_s), // R11
    .t1_in(t1_s), // R14
    .single_in(data_reg[2]),
    .pos_in(data_reg[1]), // R13
    .neg_in(data_reg[0]), // R13
    .pos_out(enc_pos),
    .neg_out(enc_neg)
  );

  // Driver off: rails quiet and output enable released
  always_ff @(posedge transmit_clock_in) begin
    if (link_rst_reg) begin
      tx_line_pos_out <= 1'b0;
      tx_line_neg_out <= 1'b0;
      tx_driver_oe_n_out <= 1'b1;
    end else begin
      tx_line_pos_out <= enc_pos && !off_s; // R8
      tx_line_neg_out <= enc_neg && !off_s; // R8
      tx_driver_oe_n_out <= off_s; // R8
    end
  end

  default clocking sys_cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_tx_term_ext: assert property (1'b1 |=> tx_term_ext_out == $past(term_reg[5])) // R1
    else $error("transmit external select wrong");
  chk_tx_term_120: assert property (term_reg[5:3] == 3'b001 |=> tx_term_ohms_out == 7'd120) // R1
    else $error("transmit 120 ohm not selected");
  chk_rx_term_110: assert property (term_reg[2:0] == 3'b011 |=> rx_term_ohms_out == 7'd110) // R3
    else $error("receive 110 ohm not selected");
  chk_limit_reset: assert property ($fell(sys_rst_in) |-> jitter_reg[5] ##1 jitter_limit_mode_out) // R4
    else $error("limit mode not set after reset");
  chk_ja_place_off: assert property (jitter_reg[4:3] == 2'b10 |=> !ja_tx_path_out && !ja_rx_path_out) // R5
    else $error("attenuator placed for off code");
  chk_ja_depth32: assert property (jitter_reg[2] |=> jitter_depth_bits_out == 8'd32) // R6
    else $error("depth not 32 bits");
  chk_corner_e1_nar: assert property ((jitter_reg[0] && !global_reg[2]) |=> jitter_corner_chz_out == 10'd90) // R7
    else $error("E1 narrow corner wrong");
  chk_resv_read: assert property ((reg_rd_in && reg_addr_in == 8'h05) |=> reg_rdata_out[7:5] == 3'b000) // R16
    else $error("reserved bits read nonzero");
  chk_wr_readback: assert property ((reg_wr_in && reg_addr_in == 8'h04) ##1 (!reg_wr_in && !reg_rd_in)
    ##1 (reg_rd_in && reg_addr_in == 8'h04) |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h3f)) // R16
    else $error("written value not read back masked");

  chk_power_down: assert property (@(posedge transmit_clock_in) disable iff (link_rst_reg)
    off_s |=> tx_driver_oe_n_out && !tx_line_pos_out && !tx_line_neg_out) // R8
    else $error("driver active while powered down");
  chk_fall_sample: assert property (@(posedge transmit_clock_in) disable iff (link_rst_reg)
    (!edge_s && !inv_s) |=> data_reg == $past(fall_smp_reg)) // R10
    else $error("falling edge sample not used");
  chk_invert: assert property (@(posedge transmit_clock_in) disable iff (link_rst_reg)
    (edge_s && inv_s) |=> data_reg == ~$past(rise_smp_reg)) // R9
    else $error("inverted data not applied");

  cov_term_write: cover property (reg_wr_in && reg_addr_in == 8'h03);
  cov_power_down: cover property (@(posedge transmit_clock_in) $rose(off_s));
  cov_dual_rail: cover property (@(posedge transmit_clock_in) mode_s[1] && !off_s);
endmodule : liu_term_jitter_tx_config

// >>> design/liu_cfg_pkg.sv
// Register map, field layout and decode constants of the configuration bank
package liu_cfg_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_GLOBAL = 8'h02;
  localparam logic [7:0] ADDR_TERM = 8'h03;
  localparam logic [7:0] ADDR_JITTER = 8'h04;
  localparam logic [7:0] ADDR_TXCFG = 8'h05;
  // Writable bits; all others are reserved
  localparam logic [7:0] MASK_GLOBAL = 8'h04;
  localparam logic [7:0] MASK_TERM = 8'h3f;
  localparam logic [7:0] MASK_JITTER = 8'h3f;
  localparam logic [7:0] MASK_TXCFG = 8'h1f;
  // Reset values
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_TERM = 8'h00;
  localparam logic [7:0] RST_JITTER = 8'h20;
  localparam logic [7:0] RST_TXCFG = 8'h00;
  // Field positions
  localparam int GLB_T1 = 2;
  localparam int TX_TERM_LSB = 3;
  localparam int RX_TERM_LSB = 0;
  localparam int TERM_EXT = 2;
  localparam int JITTER_LIMIT_MODE = 5;
  localparam int JA_PLACE_LSB = 3;
  localparam int JA_DEPTH_LSB = 1;
  localparam int JA_BW = 0;
  localparam int TX_OFF = 4;
  localparam int TX_INV = 3;
  localparam int TX_EDGE = 2;
  localparam int TX_MODE_LSB = 0;
  // Termination codes and impedances in ohms
  localparam logic [1:0] TERM_75 = 2'h0;
  localparam logic [1:0] TERM_120 = 2'h1;
  localparam logic [1:0] TERM_100 = 2'h2;
  localparam logic [6:0] OHM_75 = 7'h4b;
  localparam logic [6:0] OHM_120 = 7'h78;
  localparam logic [6:0] OHM_100 = 7'h64;
  localparam logic [6:0] OHM_110 = 7'h6e;
  localparam logic [6:0] OHM_EXT = 7'h00;
  // Jitter attenuator placement, depth and corner (0.01 Hz units)
  localparam logic [1:0] PLACE_TX = 2'h1;
  localparam logic [1:0] PLACE_RX = 2'h3;
  localparam logic [1:0] DEPTH_CODE_128 = 2'h0;
  localparam logic [1:0] DEPTH_CODE_64 = 2'h1;
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [9:0] CORNER_E1_WIDE = 10'h2a8;
  localparam logic [9:0] CORNER_T1_WIDE = 10'h1f4;
  localparam logic [9:0] CORNER_E1_NARROW = 10'h05a;
  localparam logic [9:0] CORNER_T1_NARROW = 10'h07d;
  // Transmit encoder modes; upper bit set means dual rail bypass
  localparam logic [1:0] MODE_SUBST = 2'h0;
  localparam logic [1:0] MODE_AMI = 2'h1;
  // Per-bit substitution marks in the encoder
  localparam logic [1:0] TAG_NONE = 2'h0;
  localparam logic [1:0] TAG_B = 2'h1;
  localparam logic [1:0] TAG_V = 2'h2;
  // Number of config bits carried into the transmit clock domain
  localparam int SYNC_W = 6;
endpackage : liu_cfg_pkg

// >>> design/tx_line_encoder.sv
// AMI, HDB3 and B8ZS line encoder with dual rail bypass, transmit clock domain
`timescale 1ns/10ps
module tx_line_encoder (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Mode
  input wire logic [1:0] mode_in,
  input wire logic t1_in,
  // Data
  input wire logic single_in,
  input wire logic pos_in,
  input wire logic neg_in,
  output logic pos_out,
  output logic neg_out
);
  logic [7:0] bits_reg;
  logic [15:0] tag_reg;
  logic [15:0] tag_next;
  logic last_neg_reg;
  logic odd_reg;
  logic hit_hdb3;
  logic hit_b8zs;
  logic [1:0] cur_tag;
  logic pulse;
  logic viol;
  logic neg_pol;

  // Zero runs are spotted at the oldest bit, eight bits of lookahead;
  // a run that already carries marks must not be substituted a second time
  assign hit_hdb3 = mode_in == liu_cfg_pkg::MODE_SUBST && !t1_in &&
                    bits_reg[7:4] == 4'h0 && tag_reg[15:8] == 8'h00; // R15
  assign hit_b8zs = mode_in == liu_cfg_pkg::MODE_SUBST && t1_in &&
                    bits_reg == 8'h00 && tag_reg == 16'h0000; // R15

  // Mark substituted pulses over the run
  always_comb begin
    // Marks still in flight are dropped once substitution is switched off
    tag_next = (mode_in == liu_cfg_pkg::MODE_SUBST) ? tag_reg : 16'h0000; // R12
    if (hit_hdb3) begin
      tag_next[9:8] = liu_cfg_pkg::TAG_V; // R11
      tag_next[15:14] = odd_reg ? liu_cfg_pkg::TAG_NONE : liu_cfg_pkg::TAG_B;
    end
    if (hit_b8zs) begin
      tag_next[9:8] = liu_cfg_pkg::TAG_V; // R11
      tag_next[7:6] = liu_cfg_pkg::TAG_B;
      tag_next[3:2] = liu_cfg_pkg::TAG_V;
      tag_next[1:0] = liu_cfg_pkg::TAG_B;
    end
  end

  // Violations repeat the last polarity, all else alternates
  assign cur_tag = tag_next[15:14];
  assign pulse = bits_reg[7] || cur_tag != liu_cfg_pkg::TAG_NONE;
  assign viol = cur_tag == liu_cfg_pkg::TAG_V;
  assign neg_pol = viol ? last_neg_reg : !last_neg_reg;

  // Delay line and rail outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bits_reg <= 8'h00;
      tag_reg <= 16'h0000;
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end else begin
      bits_reg <= {bits_reg[6:0], single_in};
      tag_reg <= {tag_next[13:0], liu_cfg_pkg::TAG_NONE};
      if (mode_in[1]) begin
        pos_out <= pos_in; // R13
        neg_out <= neg_in; // R13
      end else begin
        pos_out <= pulse && !neg_pol; // R12
        neg_out <= pulse && neg_pol; // R12
      end
    end
  end

  // Polarity and pulse parity since the last violation
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_neg_reg <= 1'b1;
      odd_reg <= 1'b0;
    end else if (!mode_in[1]) begin
      if (pulse) last_neg_reg <= neg_pol;
      if (viol) odd_reg <= 1'b0;
      else if (pulse) odd_reg <= !odd_reg;
    end
  end

  default clocking enc_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_dual_pass: assert property (mode_in[1] |=> pos_out == $past(pos_in) && neg_out == $past(neg_in)) // R13
    else $error("dual rail data not passed through");
  chk_ami_plain: assert property ((mode_in == liu_cfg_pkg::MODE_AMI && !bits_reg[7]) |=> !pos_out && !neg_out) // R12
    else $error("pulse sent for zero in plain AMI");
  chk_hdb3_viol: assert property ((hit_hdb3 && mode_in == $past(mode_in)) |-> ##4 (pos_out || neg_out)) // R15
    else $error("substitution pulse missing");
  chk_rails_excl: assert property (!$past(mode_in[1]) |-> !(pos_out && neg_out)) // R11
    else $error("both rails high while encoding");
  cov_hdb3_run: cover property (hit_hdb3);
  cov_b8zs_run: cover property (hit_b8zs);
endmodule : tx_line_encoder

// >>> dv/framer_tx_model.sv
// Framer side model: presents transmit NRZ data around the chosen sample edge
`timescale 1ns/10ps
module framer_tx_model (
  // Link clock and sample edge choice
  input wire logic transmit_clock_in,
  input wire logic tx_sample_edge_in,
  // Bits to present
  input wire logic single_bit_in,
  input wire logic pos_bit_in,
  input wire logic neg_bit_in,
  // Transmit data lines
  output logic single_out,
  output logic pos_out,
  output logic neg_out
);
  // New bit goes out on the edge opposite the sample edge
  task automatic launch();
    single_out <= single_bit_in;
    pos_out <= pos_bit_in;
    neg_out <= neg_bit_in;
  endtask : launch

  // Hold ends shortly after the sample edge; lines then carry the inverse,
  // so a wrong sampling edge shows up as flipped data
  task automatic expire();
    #3;
    single_out = ~single_out;
    pos_out = ~pos_out;
    neg_out = ~neg_out;
  endtask : expire

  // Lines start low
  initial begin
    single_out = 1'b0;
    pos_out = 1'b0;
    neg_out = 1'b0;
  end

  // Rising edge: launch when sampling falls, else end of hold
  always @(posedge transmit_clock_in) begin
    if (tx_sample_edge_in) begin
      expire();
    end else begin
      launch();
    end
  end

  // Falling edge: the mirror case
  always @(negedge transmit_clock_in) begin
    if (tx_sample_edge_in) begin
      launch();
    end else begin
      expire();
    end
  end
endmodule : framer_tx_model

// >>> dv/testbench.sv
// Self-checking bench for the configuration bank and its transmit path
`timescale 1ns/10ps
module testbench;
  // Clocks, reset and register port
  logic clk_in = 1'b0;
  logic transmit_clock = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  // Decoded and line outputs
  logic [6:0] tx_ohms, rx_ohms;
  logic tx_ext, rx_ext, limit, ja_tx, ja_rx, line_t1, line_pos, line_neg, oe_n;
  logic [7:0] depth;
  logic [9:0] corner;
  // Framer model stimulus and lines
  logic edge_sel = 1'b0;
  logic s_bit = 1'b0;
  logic p_bit = 1'b0;
  logic n_bit = 1'b0;
  logic s_line, p_line, n_line;
  // Bookkeeping
  int fail_count = 0;
  int cmp_count = 0;
  int npos, nneg, max_run, same;
  logic [7:0] mem [0:7];

  // 40 MHz system clock; 12 ns link clock with an unrelated phase
  always #12.5 clk_in = ~clk_in;
  initial begin
    #3.7;
    forever #6 transmit_clock = ~transmit_clock;
  end

  liu_term_jitter_tx_config u_liu_term_jitter_tx_config (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tx_term_ohms_out(tx_ohms), .tx_term_ext_out(tx_ext),
    .rx_term_ohms_out(rx_ohms), .rx_term_ext_out(rx_ext), .jitter_limit_mode_out(limit),
    .ja_tx_path_out(ja_tx), .ja_rx_path_out(ja_rx), .jitter_depth_bits_out(depth),
    .jitter_corner_chz_out(corner), .line_t1_out(line_t1), .transmit_clock_in(transmit_clock),
    .tx_single_rail_input_in(s_line), .tx_positive_rail_in(p_line),
    .tx_negative_rail_in(n_line), .tx_line_pos_out(line_pos), .tx_line_neg_out(line_neg),
    .tx_driver_oe_n_out(oe_n));

  framer_tx_model u_framer_tx_model (
    .transmit_clock_in(transmit_clock), .tx_sample_edge_in(edge_sel), .single_bit_in(s_bit),
    .pos_bit_in(p_bit), .neg_bit_in(n_bit), .single_out(s_line), .pos_out(p_line),
    .neg_out(n_line));

  // Writable bits per address; anything else reads zero
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'h02: return 8'h04;
      8'h03: return 8'h3f;
      8'h04: return 8'h3f;
      8'h05: return 8'h1f;
      default: return 8'h00;
    endcase
  endfunction : mask_of

  // Termination code to external flag and ohms
  function automatic logic [7:0] term_of(input logic [2:0] c);
    if (c[2]) return 8'h80;
    case (c[1:0])
      2'h0: return 8'h4b;
      2'h1: return 8'h78;
      2'h2: return 8'h64;
      default: return 8'h6e;
    endcase
  endfunction : term_of

  // Corner in 0.01 Hz from bandwidth bit and line standard
  function automatic logic [15:0] corner_of(input logic bw, input logic t1);
    case ({bw, t1})
      2'b00: return 16'h02a8;
      2'b01: return 16'h01f4;
      2'b10: return 16'h005a;
      default: return 16'h007d;
    endcase
  endfunction : corner_of

  // Register bus cycles, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] a);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: reg %0h read %0h expected %0h", $time, a, got, exp);
    end
  endtask : check_reg

  task automatic check_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s is %0h expected %0h", $time, what, got, exp);
    end
  endtask : check_out

  // Configure the transmitter, let the stream settle, then tally 16 line bits
  task automatic tx_case(input logic [7:0] cfg, input logic s, input logic p, input logic n);
    logic [1:0] last;
    int run;
    wr(8'h05, cfg);
    edge_sel <= cfg[2];
    s_bit <= s;
    p_bit <= p;
    n_bit <= n;
    repeat (40) @(posedge transmit_clock);
    npos = 0;
    nneg = 0;
    max_run = 0;
    same = 0;
    run = 0;
    last = 2'h0;
    repeat (16) begin
      @(negedge transmit_clock);
      if (line_pos === 1'b1 || line_neg === 1'b1) begin
        run = 0;
        if ((line_pos === 1'b1 ? 2'h1 : 2'h2) == last) same++;
        last = (line_pos === 1'b1) ? 2'h1 : 2'h2;
        if (line_pos === 1'b1) npos++;
        else nneg++;
      end else begin
        run++;
        if (run > max_run) max_run = run;
      end
    end
  endtask : tx_case

  // Negative zero-run or same-polarity expectation means that figure is not checked
  task automatic check_stream(input int ep, input int en, input int er, input int es);
    check_out(16'(npos), 16'(ep), "pos pulses");
    check_out(16'(nneg), 16'(en), "neg pulses");
    if (er >= 0) check_out(16'(max_run), 16'(er), "zero run");
    if (es >= 0) check_out(16'(same), 16'(es), "same polarity");
  endtask : check_stream

  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Watchdog far beyond the expected run of a few thousand cycles
  initial begin
    #1_000_000;
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [7:0] a, d, got;
    void'($urandom(4674));
    foreach (mem[i]) mem[i] = 8'h00;
    mem[4] = 8'h20;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle();
    check_out({tx_ext, tx_ohms, rx_ext, rx_ohms}, 16'h4b4b, "term reset");
    check_out({limit, ja_tx, ja_rx, line_t1}, 16'h0008, "ja reset");
    check_out(16'(depth), 16'h0080, "depth reset");
    check_out(16'(corner), 16'h02a8, "corner reset");
    for (int i = 2; i < 6; i++) begin
      rd(8'(i), got);
      check_reg(got, mem[i], 8'(i));
    end
    // All ones everywhere, then random traffic checked against an image
    for (int i = 0; i < 8; i++) begin
      wr(8'(i), 8'hff);
      mem[i] = mask_of(8'(i));
    end
    repeat (80) begin
      a = 8'($urandom_range(0, 7));
      d = 8'($urandom);
      if ($urandom_range(0, 1) == 1) begin
        wr(a, d);
        mem[a] = d & mask_of(a);
      end else begin
        rd(a, got);
        check_reg(got, mem[a], a);
      end
    end
    // Write then read of the same register with reserved bits set
    wr(8'h04, 8'hd5);
    mem[4] = 8'h15;
    rd(8'h04, got);
    check_reg(got, mem[4], 8'h04);
    rd(8'hc3, got);
    check_reg(got, 8'h00, 8'hc3);
    // External transmit resistors only chosen while in E1
    wr(8'h02, 8'h00);
    for (int c = 0; c < 64; c++) begin
      wr(8'h03, 8'(c) | 8'hc0);
      settle();
      check_out({tx_ext, tx_ohms, rx_ext, rx_ohms}, {term_of(3'(c >> 3)), term_of(3'(c))},
                "term");
    end
    // Every jitter setting under both line standards
    for (int t = 0; t < 2; t++) begin
      wr(8'h02, 8'(t << 2));
      for (int c = 0; c < 64; c++) begin
        wr(8'h04, 8'(c) | 8'($urandom) & 8'hc0);
        settle();
        check_out({limit, ja_tx, ja_rx, line_t1},
                  {12'h000, c[5], c[4:3] == 2'b01, c[4:3] == 2'b11, t[0]}, "ja");
        check_out(16'(depth), c[2] ? 16'h0020 : (c[1] ? 16'h0040 : 16'h0080), "depth");
        check_out(16'(corner), corner_of(c[0], t[0]), "corner");
      end
    end
    // Transmit path: dual rail on both edges, with and without inversion, then AMI and HDB3 in E1, B8ZS in T1
    wr(8'h02, 8'h00);
    for (int k = 0; k < 4; k++) begin
      tx_case({3'h0, 1'b0, k[1], k[0], 2'b10}, 1'b0, 1'b1, 1'b0);
      check_stream(k[1] ? 0 : 16, k[1] ? 16 : 0, 0, 15);
    end
    tx_case(8'h01, 1'b1, 1'b0, 1'b0);
    check_stream(8, 8, 0, 0);
    tx_case(8'h0d, 1'b0, 1'b0, 1'b0);
    check_stream(8, 8, 0, 0);
    tx_case(8'h01, 1'b0, 1'b0, 1'b0);
    check_stream(0, 0, 16, 0);
    tx_case(8'h00, 1'b0, 1'b0, 1'b0);
    check_stream(4, 4, 2, -1);
    wr(8'h02, 8'h04);
    tx_case(8'h00, 1'b0, 1'b0, 1'b0);
    check_stream(4, 4, 3, -1);
    // Power down silences the rails and releases the driver
    tx_case(8'h11, 1'b1, 1'b0, 1'b0);
    check_stream(0, 0, 16, 0);
    check_out(16'(oe_n), 16'h0001, "driver off");
    tx_case(8'h01, 1'b1, 1'b0, 1'b0);
    check_out(16'(oe_n), 16'h0000, "driver on");
    end_sim();
  end
endmodule : testbench
